// ### rtl/vss_pkg.sv
package vss_pkg;
	// ==========================================
	// register map (byte addresses)
	localparam logic [7:0] VSS_CTRL = 8'h00;
	localparam logic [7:0] VSS_SEG_X = 8'h04;
	localparam logic [7:0] VSS_SEG_Y = 8'h08;
	localparam logic [7:0] VSS_SEG_RAD = 8'h0c;
	localparam logic [7:0] VSS_SEG_ANG = 8'h10;
	localparam logic [7:0] VSS_SEG_SPD = 8'h14;
	localparam logic [7:0] VSS_SEG_PUSH = 8'h18;
	localparam logic [7:0] VSS_PATH_SPEED = 8'h1c;
	localparam logic [7:0] VSS_PATH_ACCEL = 8'h20;
	localparam logic [7:0] VSS_PATH_DECEL = 8'h24;
	localparam logic [7:0] VSS_SPEED_OVR = 8'h28;
	localparam logic [7:0] VSS_DIST_TRIP = 8'h2c;
	localparam logic [7:0] VSS_SEQ_WAIT = 8'h30;
	localparam logic [7:0] VSS_STATUS = 8'h34;
	localparam logic [7:0] VSS_FREE_SLOTS = 8'h38;
	localparam logic [7:0] VSS_SEG_COUNT = 8'h3c;
	localparam logic [7:0] VSS_SPAN_SUM = 8'h40;
	localparam logic [7:0] VSS_TRAVELED = 8'h44;
	localparam logic [7:0] VSS_LAST_POINT = 8'h48;
	// ==========================================
	// control and push field positions
	localparam int CTRL_MODE = 0;
	localparam int CTRL_BEGIN = 1;
	localparam int CTRL_CLEAR = 2;
	localparam int CTRL_HALT = 3;
	localparam int CTRL_ABORT = 4;
	localparam int CTRL_TERM = 5;
	localparam int PUSH_ARC = 0;
	localparam int PUSH_SFLAG = 1;
	localparam int PUSH_EFLAG = 2;
	// ==========================================
	// sizes, reset values, scale factors
	localparam logic [5:0] BUF_SLOTS = 6'd31;
	localparam logic [15:0] PATH_SPEED_RST = 16'h0000;
	localparam logic [15:0] PATH_ACCEL_RST = 16'h0001;
	localparam logic [15:0] PATH_DECEL_RST = 16'h0001;
	localparam logic [16:0] OVR_UNITY = 17'd10000;
	localparam logic [16:0] OVR_MAX = 17'd100000;
	localparam logic [15:0] ARC_K = 16'd1144;
	localparam int SERVO_TICK_NS = 1000000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int TICK_CYCLES = SERVO_TICK_NS / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_HALT = 2'b10
	} vss_state_e;
endpackage

// ### rtl/vss_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module vss_sequencer #(
	parameter int TICK_LEN = vss_pkg::TICK_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [31:0] axis_position,
	output logic [19:0] path_velocity,
	output logic [31:0] path_distance,
	output logic seq_active
);
	import vss_pkg::*;

	// ==========================================
	// state
	vss_state_e state;
	logic coord_en, term_seen, stale;
	logic [4:0] head, tail;
	logic [5:0] count;
	logic [31:0] seg_x, seg_y, seg_rad, seg_ang, seg_spd, prev_x, prev_y;
	logic [15:0] path_speed, path_accel, path_decel;
	logic [16:0] speed_ovr;
	logic [31:0] span, traveled, seg_cnt, last_point, origin;
	logic [19:0] vel;
	logic [15:0] tick_cnt;
	logic dist_arm, seq_arm;
	logic [31:0] dist_target;
	logic [31:0] buf_end [0:31];
	logic [31:0] buf_x [0:31];
	logic [15:0] buf_sspd [0:31];
	logic [15:0] buf_espd [0:31];
	logic [31:0] buf_sflag, buf_eflag;
	logic dp_valid, dp_write, dp_hit, rd_first;
	logic [7:0] dp_addr;

	// lowest set bit of a vector, msb of result says found
	function automatic logic [5:0] first_set(input logic [31:0] v);
		logic [5:0] r;
		r = 6'd0;
		for (int i = 31; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] mag32(input logic [31:0] v);
		return v[31] ? 32'(-v) : v;
	endfunction

	// ==========================================
	// bus decode
	wire addr_take = hready & hsel & htrans[1];
	wire hold_dist = dist_arm & (traveled < dist_target);
	wire hold_seq = seq_arm & (state != ST_IDLE);
	wire blocked = (hold_dist | hold_seq) & (dp_addr != VSS_CTRL);
	wire wr = dp_valid & dp_write & dp_hit & hreadyout;
	wire wr_ctrl = wr & (dp_addr == VSS_CTRL);
	wire do_begin = wr_ctrl & hwdata[CTRL_BEGIN] & (state == ST_IDLE) & coord_en & (count != 6'd0);
	wire do_clear = wr_ctrl & hwdata[CTRL_CLEAR] & (state == ST_IDLE);
	wire do_halt = wr_ctrl & hwdata[CTRL_HALT] & (state == ST_RUN);
	wire do_abort = wr_ctrl & hwdata[CTRL_ABORT] & (state != ST_IDLE);
	wire do_term = wr_ctrl & hwdata[CTRL_TERM] & coord_en;
	wire do_push = wr & (dp_addr == VSS_SEG_PUSH) & coord_en & (count < BUF_SLOTS);
	assign hreadyout = ~(dp_valid & (rd_first | blocked));
	assign hresp = 1'b0;

	// address phase capture; reads take one wait cycle, and a read released
	// from a trippoint stall waits once more so it returns post-stall data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_hit <= 1'b0;
			dp_addr <= 8'h00;
			rd_first <= 1'b0;
		end else if (hready) begin
			dp_valid <= hsel & htrans[1];
			dp_write <= hwrite;
			dp_hit <= (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'b00);
			dp_addr <= haddr[7:0];
			rd_first <= addr_take & ~hwrite;
		end else begin
			rd_first <= blocked & ~dp_write;
		end
	end

	// ==========================================
	// segment length at push
	wire [31:0] adx = mag32(seg_x - prev_x);
	wire [31:0] ady = mag32(seg_y - prev_y);
	wire [31:0] lmax = (adx > ady) ? adx : ady;
	wire [31:0] lmin = (adx > ady) ? ady : adx;
	// octagon estimate of the hypotenuse, within about 7 percent, no root extractor
	wire [31:0] line_len = lmax + (lmin >> 2) + (lmin >> 3);
	wire [15:0] adang = seg_ang[31] ? 16'(-seg_ang[31:16]) : seg_ang[31:16];
	wire [63:0] arc_prod = 64'(seg_rad) * 64'(adang) * 64'(ARC_K);
	wire [31:0] seg_len = hwdata[PUSH_ARC] ? arc_prod[47:16] : line_len;
	wire [31:0] span_base = stale ? 32'h0 : span;
	wire [31:0] new_end = span_base + seg_len;

	// ==========================================
	// profile generator
	wire tick = (tick_cnt == 16'(TICK_LEN - 1));
	wire [31:0] rot_e = buf_eflag >> head | buf_eflag << (6'd32 - {1'b0, head});
	wire [31:0] valid_mask = (count == 6'd32) ? 32'hffffffff : ((32'h1 << count) - 32'h1);
	wire [5:0] cfind = first_set(rot_e & valid_mask);
	wire [4:0] cidx = cfind[4:0] + head;
	// nearest upcoming end speed masks later ones, terminator comes last
	wire c_act = cfind[5] | term_seen | (state == ST_HALT);
	wire [31:0] c_end = cfind[5] ? buf_end[cidx] : span;
	wire [19:0] c_spd = cfind[5] ? 20'(buf_espd[cidx]) : 20'h0;
	wire [15:0] cmd_spd = buf_sflag[head] ? buf_sspd[head] : path_speed;
	wire [35:0] scaled = (36'(cmd_spd) * 36'(speed_ovr)) / 36'(OVR_UNITY);
	wire [19:0] target = (state == ST_HALT) ? 20'h0 : scaled[19:0];
	wire [31:0] rem = (c_end > traveled) ? c_end - traveled : 32'h0;
	wire [31:0] rem_after = (rem > 32'(vel)) ? rem - 32'(vel) : 32'h0;
	wire [49:0] v_sq = 50'(vel) * 50'(vel);
	wire [49:0] brake = 50'(c_spd) * 50'(c_spd) + 50'(path_decel) * 50'(rem_after) * 50'd2;
	wire need_dec = (state == ST_HALT) | (c_act & (vel > c_spd) & (v_sq >= brake));
	wire [19:0] v_dn = (vel > 20'(path_decel)) ? vel - 20'(path_decel) : 20'h0;
	wire [19:0] v_upr = vel + 20'(path_accel);
	wire [19:0] v_up = (v_upr > target) ? target : v_upr;
	wire [19:0] floor_v = (need_dec & (c_spd < target) & (state == ST_RUN)) ? c_spd : target;
	wire [19:0] v_dnf = (v_dn < floor_v) ? floor_v : v_dn;
	wire [19:0] v_calc = (need_dec | (vel > target)) ? v_dnf : v_up;
	// crawl at one count per tick so a rounded-down brake cannot stall short
	wire [19:0] next_vel = ((state == ST_RUN) & (v_calc == 20'h0) & (target != 20'h0)) ? 20'h1 : v_calc;
	wire [31:0] adv = traveled + 32'(next_vel);
	wire at_end = adv >= buf_end[head];
	wire run_tick = tick & (state != ST_IDLE) & ~do_abort;
	wire pop = run_tick & at_end;
	wire last_seg = (count == 6'd1) & ~do_push;
	wire stop_now = do_abort | (pop & last_seg) | (run_tick & (state == ST_HALT) & (next_vel == 20'h0));

	// servo update tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt <= 16'h0;
		end else begin
			tick_cnt <= tick ? 16'h0 : tick_cnt + 16'h1;
		end
	end

	// sequence state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_IDLE;
		end else if (stop_now) begin
			state <= ST_IDLE;
		end else if (do_halt) begin
			state <= ST_HALT;
		end else begin
			case (state)
				ST_IDLE: state <= do_begin ? ST_RUN : ST_IDLE;
				ST_RUN: state <= ST_RUN;
				ST_HALT: state <= ST_HALT;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// path motion counters
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			vel <= 20'h0;
			traveled <= 32'h0;
			seg_cnt <= 32'h0;
			origin <= 32'h0;
			last_point <= 32'h0;
		end else if (do_begin) begin
			origin <= axis_position;
			last_point <= axis_position;
			traveled <= 32'h0;
			seg_cnt <= 32'h0;
			vel <= 20'h0;
		end else if (stop_now & ~pop) begin
			vel <= 20'h0;
		end else if (run_tick) begin
			vel <= (pop & last_seg) ? 20'h0 : next_vel;
			traveled <= at_end ? buf_end[head] : adv;
			if (pop) begin
				seg_cnt <= seg_cnt + 32'h1;
				last_point <= origin + buf_x[head];
			end
		end
	end

	// ==========================================
	// segment queue
	always_ff @(posedge hclk) begin
		if (do_push) begin
			buf_end[tail] <= new_end;
			buf_x[tail] <= seg_x;
			buf_sspd[tail] <= seg_spd[15:0];
			buf_espd[tail] <= seg_spd[31:16];
		end
	end

	// pointers, flags and sequence length
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			head <= 5'h0;
			tail <= 5'h0;
			count <= 6'h0;
			buf_sflag <= 32'h0;
			buf_eflag <= 32'h0;
			span <= 32'h0;
			prev_x <= 32'h0;
			prev_y <= 32'h0;
			term_seen <= 1'b0;
			stale <= 1'b0;
		end else if (stop_now | do_clear) begin
			head <= 5'h0;
			tail <= 5'h0;
			count <= 6'h0;
			buf_eflag <= 32'h0;
			term_seen <= 1'b0;
			stale <= 1'b1;
			prev_x <= 32'h0;
			prev_y <= 32'h0;
		end else begin
			if (do_term) begin
				term_seen <= 1'b1;
			end
			if (do_push) begin
				tail <= tail + 5'h1;
				buf_sflag[tail] <= hwdata[PUSH_SFLAG];
				buf_eflag[tail] <= hwdata[PUSH_EFLAG];
				span <= new_end;
				stale <= 1'b0;
				prev_x <= seg_x;
				prev_y <= seg_y;
			end
			if (pop) begin
				head <= head + 5'h1;
				buf_eflag[head] <= 1'b0;
			end
			count <= count + {5'h0, do_push} - {5'h0, pop};
		end
	end

	// ==========================================
	// software registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			coord_en <= 1'b0;
			seg_x <= 32'h0;
			seg_y <= 32'h0;
			seg_rad <= 32'h0;
			seg_ang <= 32'h0;
			seg_spd <= 32'h0;
			path_speed <= PATH_SPEED_RST;
			path_accel <= PATH_ACCEL_RST;
			path_decel <= PATH_DECEL_RST;
			speed_ovr <= OVR_UNITY;
		end else if (wr) begin
			case (dp_addr)
				VSS_CTRL: coord_en <= hwdata[CTRL_MODE];
				VSS_SEG_X: seg_x <= hwdata;
				VSS_SEG_Y: seg_y <= hwdata;
				VSS_SEG_RAD: seg_rad <= hwdata;
				VSS_SEG_ANG: seg_ang <= hwdata;
				VSS_SEG_SPD: seg_spd <= hwdata;
				VSS_PATH_SPEED: path_speed <= hwdata[15:0];
				VSS_PATH_ACCEL: path_accel <= hwdata[15:0];
				VSS_PATH_DECEL: path_decel <= hwdata[15:0];
				// out-of-range factors clamp to the ten-times ceiling
				VSS_SPEED_OVR: speed_ovr <= (hwdata > 32'(OVR_MAX)) ? OVR_MAX : hwdata[16:0];
				default: coord_en <= coord_en;
			endcase
		end
	end

	// trippoints; arming wins over release in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dist_arm <= 1'b0;
			seq_arm <= 1'b0;
			dist_target <= 32'h0;
		end else begin
			if (wr & (dp_addr == VSS_DIST_TRIP)) begin
				dist_arm <= 1'b1;
				dist_target <= traveled + hwdata;
			end else if (~hold_dist | (state == ST_IDLE)) begin
				dist_arm <= 1'b0;
			end
			if (wr & (dp_addr == VSS_SEQ_WAIT)) begin
				seq_arm <= 1'b1;
			end else if (~hold_seq) begin
				seq_arm <= 1'b0;
			end
		end
	end

	// ==========================================
	// read back
	wire [31:0] status_word = {26'h0, hold_seq, hold_dist, term_seen, coord_en, state == ST_HALT, state != ST_IDLE};
	wire [31:0] free_slots = 32'(BUF_SLOTS - count);
	wire [31:0] rd_mux =
		!dp_hit ? 32'h0 :
		(dp_addr == VSS_CTRL) ? {31'h0, coord_en} :
		(dp_addr == VSS_SEG_X) ? seg_x :
		(dp_addr == VSS_SEG_Y) ? seg_y :
		(dp_addr == VSS_SEG_RAD) ? seg_rad :
		(dp_addr == VSS_SEG_ANG) ? seg_ang :
		(dp_addr == VSS_SEG_SPD) ? seg_spd :
		(dp_addr == VSS_PATH_SPEED) ? {16'h0, path_speed} :
		(dp_addr == VSS_PATH_ACCEL) ? {16'h0, path_accel} :
		(dp_addr == VSS_PATH_DECEL) ? {16'h0, path_decel} :
		(dp_addr == VSS_SPEED_OVR) ? {15'h0, speed_ovr} :
		(dp_addr == VSS_STATUS) ? status_word :
		(dp_addr == VSS_FREE_SLOTS) ? free_slots :
		(dp_addr == VSS_SEG_COUNT) ? seg_cnt :
		(dp_addr == VSS_SPAN_SUM) ? {1'b0, span[30:0]} :
		(dp_addr == VSS_TRAVELED) ? traveled :
		(dp_addr == VSS_LAST_POINT) ? last_point : 32'h0;

	// registered read data and axis-side outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
			path_velocity <= 20'h0;
			path_distance <= 32'h0;
			seq_active <= 1'b0;
		end else begin
			// load only in wait cycles so the answer stands until the next read
			if (dp_valid & ~dp_write & ~hreadyout) begin
				hrdata <= rd_mux;
			end
			path_velocity <= vel;
			path_distance <= traveled;
			seq_active <= state != ST_IDLE;
		end
	end
endmodule // vss_sequencer
`default_nettype wire

// ### test/vss_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// port-level checker for the sequencer
module vss_sequencer_asserts
	import vss_pkg::*;
#(
	parameter int TICK_LEN = 20
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] axis_position,
	input wire logic [19:0] path_velocity,
	input wire logic [31:0] path_distance,
	input wire logic seq_active
);
	// address phase accepted by the slave
	wire logic taken = hsel & htrans[1] & hready;
	wire logic to_ctrl = (haddr == {24'h000000, VSS_CTRL});
	logic rd_dp;
	// tracks an open read data phase so hold checks skip it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_dp <= 1'b0;
		end else if (taken) begin
			rd_dp <= !hwrite;
		end else if (hreadyout) begin
			rd_dp <= 1'b0;
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence ctrl_read;
		taken && !hwrite && to_ctrl;
	endsequence
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	// ==========================================
	// bus timing
	AST_CTRL_RD: assert property (ctrl_read |=> one_wait)
		else $error("control read not answered after one wait");
	AST_RD_WAIT: assert property (taken && !hwrite |=> !hreadyout)
		else $error("read answered without a wait cycle");
	AST_CTRL_WR: assert property (taken && hwrite && to_ctrl |=> hreadyout)
		else $error("control write stalled");
	AST_OKAY: assert property (hresp == 1'b0)
		else $error("response not okay");
	AST_HOLD: assert property (!rd_dp |-> $stable(hrdata))
		else $error("read data changed outside a read");
	// ==========================================
	// motion outputs
	AST_IDLE_VEL: assert property (!seq_active && !$past(seq_active) |-> path_velocity == 20'h00000)
		else $error("velocity nonzero while idle");
	AST_IDLE_DIST: assert property (!seq_active && !$past(seq_active) && !$past(seq_active, 2)
		|-> $stable(path_distance))
		else $error("distance moved while idle");
	AST_DIST_UP: assert property (seq_active && $past(seq_active) && $past(seq_active, 2)
		|-> path_distance >= $past(path_distance))
		else $error("distance went backwards in motion");
	COV_RUN: cover property ($rose(seq_active));
endmodule // vss_sequencer_asserts
bind vss_sequencer vss_sequencer_asserts #(.TICK_LEN(TICK_LEN)) vss_sequencer_asserts_inst (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.axis_position(axis_position), .path_velocity(path_velocity), .path_distance(path_distance),
	.seq_active(seq_active));
`default_nettype wire

// ### test/vss_axis_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// axis position loop: integrates path speed once per servo tick
module vss_axis_model #(
	parameter int TICK_LEN = 20,
	parameter logic [31:0] START_POS = 32'h000003e8
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [19:0] path_velocity,
	input wire logic seq_active,
	output logic [31:0] axis_position
);
	int cnt;
	// position stands still while idle, so the start origin is well defined
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			axis_position <= START_POS;
			cnt <= 0;
		end else if (seq_active) begin
			cnt <= (cnt == TICK_LEN - 1) ? 0 : cnt + 1;
			if (cnt == TICK_LEN - 1) begin
				axis_position <= axis_position + {12'h000, path_velocity};
			end
		end
	end
endmodule // vss_axis_model
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import vss_pkg::*;
	localparam int TICK = 20;
	localparam int WMAX = 20000;
	localparam logic [31:0] ORIGIN = 32'h000003e8;
	typedef struct packed {logic wr; logic [7:0] addr; logic [31:0] wd; logic [31:0] exp;} vss_row_s;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, path_distance, axis_position, q;
	logic hreadyout, hresp, seq_active;
	logic [19:0] path_velocity;
	wire logic hready = hreadyout;
	int error_cnt = 0;
	int n_compared = 0;
	// ==========================================
	// reset values, readback, clamp and unmapped place
	vss_row_s rows [14] = '{'{1'b0, VSS_FREE_SLOTS, 32'h0, 32'h1f}, '{1'b0, VSS_PATH_SPEED, 32'h0, 32'h0},
		'{1'b0, VSS_PATH_ACCEL, 32'h0, 32'h1}, '{1'b0, VSS_PATH_DECEL, 32'h0, 32'h1},
		'{1'b0, VSS_SPEED_OVR, 32'h0, 32'h2710}, '{1'b0, VSS_SEG_COUNT, 32'h0, 32'h0},
		'{1'b0, VSS_STATUS, 32'h0, 32'h0}, '{1'b0, VSS_CTRL, 32'h0, 32'h0}, '{1'b1, 8'h4c, 32'h5, 32'h0},
		'{1'b1, VSS_SPEED_OVR, 32'h30d40, 32'h186a0}, '{1'b1, VSS_SPEED_OVR, 32'h2710, 32'h2710},
		'{1'b1, VSS_PATH_SPEED, 32'h4, 32'h4}, '{1'b1, VSS_PATH_ACCEL, 32'h4, 32'h4},
		'{1'b1, VSS_PATH_DECEL, 32'h4, 32'h4}};
	vss_sequencer #(.TICK_LEN(TICK)) vss_sequencer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .axis_position(axis_position),
		.path_velocity(path_velocity), .path_distance(path_distance), .seq_active(seq_active));
	vss_axis_model #(.TICK_LEN(TICK), .START_POS(ORIGIN)) vss_axis_model_inst (.hclk(hclk),
		.hresetn(hresetn), .path_velocity(path_velocity), .seq_active(seq_active),
		.axis_position(axis_position));
	initial begin
		forever #25 hclk = ~hclk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d, mismatched %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// waits for hready high at the coming edge; entered just after a rising edge
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while (hready !== 1'b1 && n < WMAX);
		if (n >= WMAX) error_cnt++;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h000000, a};
		hwrite <= w;
		wait_ready();
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		rd = hrdata;
		@(posedge hclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask
	task automatic push(input logic [31:0] x, input logic [31:0] f);
		wr(VSS_SEG_X, x);
		wr(VSS_SEG_Y, 32'h0);
		wr(VSS_SEG_PUSH, f);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (seq_active !== 1'b0 && n < WMAX) begin
			@(posedge hclk);
			n++;
		end
		if (n >= WMAX) error_cnt++;
	endtask
	// watchdog sized well past the longest motion here
	initial begin
		#(50 * 40000);
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge hclk);
		check({11'h0, seq_active, path_velocity}, 32'h0);
		check({31'h0, hreadyout}, 32'h1);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rows[i]) begin
			if (rows[i].wr) wr(rows[i].addr, rows[i].wd);
			bus(1'b0, rows[i].addr, 32'h0, q);
			check(q, rows[i].exp);
		end
		$display("table test done");
		// buffer: mode off refuses, fill to refusal, clear
		wr(VSS_SEG_RAD, 32'h64);
		wr(VSS_SEG_ANG, 32'h005a0000);
		push(32'h10, 32'h1);
		bus(1'b0, VSS_FREE_SLOTS, 32'h0, q);
		check(q, 32'h1f);
		wr(VSS_CTRL, 32'h1);
		for (int i = 0; i < 32; i++) push(32'h10 * (i + 1), (i == 0) ? 32'h1 : 32'h0);
		bus(1'b0, VSS_FREE_SLOTS, 32'h0, q);
		check(q, 32'h0);
		// quarter circle of radius 100 is 157, then thirty 16-count lines
		bus(1'b0, VSS_SPAN_SUM, 32'h0, q);
		check(q, 32'h27d);
		wr(VSS_CTRL, 32'h5);
		bus(1'b0, VSS_FREE_SLOTS, 32'h0, q);
		check(q, 32'h1f);
		$display("buffer test done");
		// two absolute lines with terminator, wait on completion trippoint
		push(32'h28, 32'h0);
		push(32'h50, 32'h0);
		wr(VSS_CTRL, 32'h21);
		wr(VSS_CTRL, 32'h3);
		wr(VSS_SEQ_WAIT, 32'h1);
		bus(1'b0, VSS_STATUS, 32'h0, q);
		check({31'h0, q[0]}, 32'h0);
		bus(1'b0, VSS_TRAVELED, 32'h0, q);
		check(q, 32'h50);
		bus(1'b0, VSS_SPAN_SUM, 32'h0, q);
		check(q, 32'h50);
		bus(1'b0, VSS_LAST_POINT, 32'h0, q);
		check(q, ORIGIN + 32'h50);
		bus(1'b0, VSS_SEG_COUNT, 32'h0, q);
		check(q, 32'h2);
		bus(1'b0, VSS_FREE_SLOTS, 32'h0, q);
		check(q, 32'h1f);
		check({12'h0, path_velocity}, 32'h0);
		$display("sequence test done");
		// long line: distance trippoint, override, ramped halt
		push(32'h190, 32'h0);
		wr(VSS_CTRL, 32'h3);
		wr(VSS_DIST_TRIP, 32'h14);
		bus(1'b0, VSS_TRAVELED, 32'h0, q);
		check({31'h0, q >= 32'h14}, 32'h1);
		wr(VSS_SPEED_OVR, 32'h1388);
		repeat (10 * TICK) @(posedge hclk);
		check({12'h0, path_velocity}, 32'h2);
		wr(VSS_SPEED_OVR, 32'h2710);
		wr(VSS_PATH_DECEL, 32'h1);
		repeat (5 * TICK) @(posedge hclk);
		wr(VSS_CTRL, 32'h9);
		repeat (2) @(posedge hclk);
		check({31'h0, seq_active}, 32'h1);
		wait_idle();
		check({12'h0, path_velocity}, 32'h0);
		$display("halt test done");
		// abort stops without ramp
		push(32'h190, 32'h0);
		wr(VSS_CTRL, 32'h3);
		repeat (5 * TICK) @(posedge hclk);
		wr(VSS_CTRL, 32'h11);
		repeat (2) @(posedge hclk);
		check({11'h0, seq_active, path_velocity}, 32'h0);
		bus(1'b0, VSS_FREE_SLOTS, 32'h0, q);
		check(q, 32'h1f);
		$display("abort test done");
		// one terminated line with start speed 2 and end speed 1
		wr(VSS_SEG_SPD, 32'h00010002);
		push(32'h190, 32'h6);
		wr(VSS_CTRL, 32'h21);
		wr(VSS_CTRL, 32'h3);
		repeat (10 * TICK) @(posedge hclk);
		check({12'h0, path_velocity}, 32'h2);
		for (int k = 0; k < WMAX && path_velocity !== 20'h1; k++) @(posedge hclk);
		check({31'h0, path_distance >= 32'h18c && path_distance <= 32'h190}, 32'h1);
		wait_idle();
		check(path_distance, 32'h190);
		$display("speed test done");
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
